// [shared/zch_pkg.sv]
// Constants and types shared by the zero command handler
`default_nettype none
package zch_pkg;
	localparam int unsigned CLK_HZ           = 10_000_000;
	localparam int unsigned WEIGHT_W         = 24;
	localparam int unsigned CHAR_BITS        = 8;
	// Stability wait, in milliseconds, per device type
	localparam int unsigned STAB_TIMEOUT_MS  = 2000;
	localparam int unsigned STAB_TIMEOUT_CYC =
		STAB_TIMEOUT_MS * (CLK_HZ / 1000);
	localparam int unsigned SYNC_CTS         = 0;
	localparam int unsigned SYNC_APPROVED    = 1;
	localparam int unsigned SYNC_HS_EN       = 2;

	typedef enum logic [3:0] {
		RESP_SERIAL_ID,
		RESP_ZERO_ACK,
		RESP_ZERO_BUSY,
		RESP_ZERO_PLUS,
		RESP_ZERO_MINUS,
		RESP_IMM_DYN,
		RESP_IMM_STABLE,
		RESP_IMM_BUSY,
		RESP_IMM_PLUS,
		RESP_IMM_MINUS,
		RESP_UNSUPPORTED
	} zch_resp_type;

	localparam zch_resp_type RESP_RESET = RESP_SERIAL_ID;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_WAIT,
		ST_RESP
	} zch_state_type;
endpackage : zch_pkg
`default_nettype wire

// [hw/zch_zero_handler.sv]
// Zero command handler: stable and immediate zeroing, tare and replies
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Stable zero sets new zero reference
// - Zeroing clears tare, net equals gross
// - Stable zero success replies acceptance code
// - Busy or stability timeout replies not-executable
// - Stability timeout is a device-type parameter
// - Above range replies plus, no zeroing
// - Below range replies minus, no zeroing
// - Power-up zero and ranges stay untouched
// - Successful zeroing clears tare memory
// - Immediate zero sets zero without waiting
// - Unstable immediate zero replies dynamic code
// - Stable immediate zero replies stable code
// - Busy immediate zero replies busy, keeps zero
// - Approved unit refuses immediate zero
// - Serial-number identification sent after power-up
// - Both ends share baud, bits, parity
// - Eight-bit characters carry codes above 127
// - No-handshake setting ignores CTS and DTR
module zch_zero_handler #(
	parameter int unsigned W           = zch_pkg::WEIGHT_W,
	parameter int unsigned DATA_BITS   = zch_pkg::CHAR_BITS,
	parameter int unsigned TIMEOUT_CYC = zch_pkg::STAB_TIMEOUT_CYC
) (
	input  wire logic                  clk,
	input  wire logic                  rst,
	input  wire logic                  cmd_valid,
	input  wire logic                  cmd_imm,
	output var  logic                  cmd_ready,
	output var  logic                  resp_valid,
	output var  zch_pkg::zch_resp_type resp_code,
	input  wire logic                  resp_ready,
	input  wire logic                  other_busy,
	input  wire logic                  weight_stable,
	input  wire logic signed [W-1:0]   raw_weight,
	input  wire logic                  pu_capture,
	input  wire logic signed [W-1:0]   zero_hi,
	input  wire logic signed [W-1:0]   zero_lo,
	input  wire logic                  tare_load,
	input  wire logic signed [W-1:0]   tare_value,
	input  wire logic                  cts_pin,
	input  wire logic                  approved_pin,
	input  wire logic                  hs_enable_pin,
	output var  logic signed [W-1:0]   zero_ref,
	output var  logic signed [W-1:0]   tare,
	output var  logic signed [W-1:0]   gross,
	output var  logic signed [W-1:0]   net
);
	localparam int unsigned CW = $clog2(TIMEOUT_CYC + 1);

	if (W < 8 || DATA_BITS != 8 || TIMEOUT_CYC < 2) begin : g_bad_params
		$error("zch_zero_handler: unsupported parameters");
	end

	zch_pkg::zch_state_type state_r;
	logic [2:0]             sync1_r;
	logic [2:0]             sync2_r;
	logic [CW-1:0]          wait_cnt_r;
	logic signed [W-1:0]    pu_zero_r;
	logic                   id_sent_r;
	logic signed [W:0]      offset;
	logic                   over;
	logic                   under;
	logic                   in_range;
	logic                   go;
	logic                   line_ok;
	logic                   timeout;
	logic                   zero_do;

	function automatic zch_pkg::zch_resp_type pick(
		input logic imm,
		input zch_pkg::zch_resp_type z_code,
		input zch_pkg::zch_resp_type zi_code
	);
		pick = imm ? zi_code : z_code;
	endfunction : pick

	function automatic zch_pkg::zch_resp_type range_code(
		input logic imm,
		input logic hi,
		input logic lo,
		input zch_pkg::zch_resp_type ok_code
	);
		if (hi) begin
			range_code = pick(imm, zch_pkg::RESP_ZERO_PLUS,
				zch_pkg::RESP_IMM_PLUS);
		end else if (lo) begin
			range_code = pick(imm, zch_pkg::RESP_ZERO_MINUS,
				zch_pkg::RESP_IMM_MINUS);
		end else begin
			range_code = ok_code;
		end
	endfunction : range_code

	// Pins from outside the clock domain
	always_ff @(posedge clk) begin
		if (rst) begin
			sync1_r <= 3'h0;
			sync2_r <= 3'h0;
		end else begin
			sync1_r <= {hs_enable_pin, approved_pin, cts_pin};
			sync2_r <= sync1_r;
		end
	end

	assign line_ok = !sync2_r[zch_pkg::SYNC_HS_EN]
		|| sync2_r[zch_pkg::SYNC_CTS];
	assign offset  = (W+1)'(raw_weight) - (W+1)'(pu_zero_r);
	assign over    = offset > (W+1)'(zero_hi);
	assign under   = offset < (W+1)'(zero_lo);
	assign in_range = !over && !under;
	assign go      = cmd_valid && cmd_ready;
	assign timeout = wait_cnt_r == CW'(TIMEOUT_CYC - 1);
	assign zero_do = (state_r == zch_pkg::ST_IDLE && go && !other_busy
		&& cmd_imm && !sync2_r[zch_pkg::SYNC_APPROVED] && in_range)
		|| (state_r == zch_pkg::ST_WAIT && weight_stable && in_range);

	// Command sequencing and reply selection
	always_ff @(posedge clk) begin
		if (rst) begin
			state_r   <= zch_pkg::ST_RESP;
			resp_code <= zch_pkg::RESP_RESET;
			cmd_ready <= 1'b0;
		end else begin
			case (state_r)
			zch_pkg::ST_IDLE: begin
				if (go) begin
					cmd_ready <= 1'b0;
					state_r   <= zch_pkg::ST_RESP;
					if (other_busy) begin
						resp_code <= pick(cmd_imm,
							zch_pkg::RESP_ZERO_BUSY,
							zch_pkg::RESP_IMM_BUSY);
					end else if (cmd_imm
						&& sync2_r[zch_pkg::SYNC_APPROVED]) begin
						resp_code <= zch_pkg::RESP_UNSUPPORTED;
					end else if (cmd_imm) begin
						resp_code <= range_code(1'b1, over, under,
							weight_stable ? zch_pkg::RESP_IMM_STABLE
							: zch_pkg::RESP_IMM_DYN);
					end else begin
						state_r <= zch_pkg::ST_WAIT;
					end
				end
			end
			zch_pkg::ST_WAIT: begin
				if (weight_stable) begin
					resp_code <= range_code(1'b0, over, under,
						zch_pkg::RESP_ZERO_ACK);
					state_r   <= zch_pkg::ST_RESP;
				end else if (timeout) begin
					resp_code <= zch_pkg::RESP_ZERO_BUSY;
					state_r   <= zch_pkg::ST_RESP;
				end
			end
			zch_pkg::ST_RESP: begin
				if (resp_valid && resp_ready) begin
					state_r   <= zch_pkg::ST_IDLE;
					cmd_ready <= 1'b1;
				end
			end
			default: begin
				state_r   <= zch_pkg::ST_IDLE;
				cmd_ready <= 1'b1;
			end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst || state_r != zch_pkg::ST_WAIT) begin
			wait_cnt_r <= '0;
		end else if (!timeout) begin
			// Hold at the limit so the count never passes it
			wait_cnt_r <= wait_cnt_r + CW'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			resp_valid <= 1'b0;
			id_sent_r  <= 1'b0;
		end else if (resp_valid && resp_ready) begin
			resp_valid <= 1'b0;
			id_sent_r  <= 1'b1;
		end else if (state_r == zch_pkg::ST_RESP && line_ok) begin
			resp_valid <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pu_zero_r <= '0;
		end else if (pu_capture) begin
			pu_zero_r <= raw_weight;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			zero_ref <= '0;
			tare     <= '0;
		end else if (zero_do) begin
			zero_ref <= raw_weight;
			tare     <= '0;
		end else if (tare_load) begin
			tare <= tare_value;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			gross <= '0;
			net   <= '0;
		end else begin
			gross <= W'(raw_weight - zero_ref);
			net   <= W'(raw_weight - zero_ref - tare);
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	a_zero_takes_raw: assert property (
		zero_do |=> zero_ref == $past(raw_weight) && tare == '0)
		else $error("zeroing did not load reference and clear tare");
	a_net_equals_gross: assert property (
		zero_do ##1 !tare_load |=> net == gross)
		else $error("net differs from gross after zeroing");
	a_stable_ack: assert property (
		state_r == zch_pkg::ST_WAIT && weight_stable && in_range
		|=> resp_code == zch_pkg::RESP_ZERO_ACK
		##1 resp_valid || !$past(line_ok))
		else $error("stable zero not acknowledged");
	a_timeout_busy: assert property (
		state_r == zch_pkg::ST_WAIT && timeout && !weight_stable
		|=> resp_code == zch_pkg::RESP_ZERO_BUSY && $stable(zero_ref))
		else $error("timeout did not give busy reply");
	a_wait_bound: assert property (
		wait_cnt_r <= CW'(TIMEOUT_CYC - 1))
		else $error("stability wait overran its limit");
	a_over_reject: assert property (
		state_r == zch_pkg::ST_WAIT && weight_stable && over
		|=> resp_code == zch_pkg::RESP_ZERO_PLUS && $stable(zero_ref))
		else $error("upper range not rejected");
	a_under_reject: assert property (
		go && !other_busy && cmd_imm && !over && under
		&& !sync2_r[zch_pkg::SYNC_APPROVED]
		|=> resp_code == zch_pkg::RESP_IMM_MINUS && $stable(zero_ref))
		else $error("lower range not rejected");
	a_pu_zero_kept: assert property (
		!pu_capture |=> $stable(pu_zero_r))
		else $error("power-up zero changed");
	a_imm_code: assert property (
		go && cmd_imm && !other_busy && in_range
		&& !sync2_r[zch_pkg::SYNC_APPROVED]
		|=> resp_code == ($past(weight_stable)
			? zch_pkg::RESP_IMM_STABLE : zch_pkg::RESP_IMM_DYN))
		else $error("immediate zero condition code wrong");
	a_busy_keeps: assert property (
		go && other_busy |=> $stable(zero_ref)
		&& state_r == zch_pkg::ST_RESP)
		else $error("busy command changed zero");
	a_approved_refuse: assert property (
		go && cmd_imm && !other_busy && sync2_r[zch_pkg::SYNC_APPROVED]
		|=> resp_code == zch_pkg::RESP_UNSUPPORTED && $stable(zero_ref))
		else $error("approved unit executed immediate zero");
	a_id_first: assert property (
		resp_valid && !id_sent_r
		|-> resp_code == zch_pkg::RESP_SERIAL_ID)
		else $error("first reply is not identification");
	a_no_hs_send: assert property (
		!sync2_r[zch_pkg::SYNC_HS_EN] && state_r == zch_pkg::ST_RESP
		&& !resp_valid |=> resp_valid)
		else $error("reply held without handshake");
	a_one_reply: assert property (
		resp_valid && resp_ready
		|=> !resp_valid && cmd_ready && state_r == zch_pkg::ST_IDLE)
		else $error("reply and command acceptance out of order");

	c_stable_ack: cover property (
		resp_valid && resp_code == zch_pkg::RESP_ZERO_ACK);
	c_imm_dyn: cover property (
		resp_valid && resp_code == zch_pkg::RESP_IMM_DYN);
	c_timeout: cover property (
		state_r == zch_pkg::ST_WAIT && timeout && !weight_stable);
	c_plus: cover property (
		resp_valid && resp_code == zch_pkg::RESP_ZERO_PLUS);
endmodule : zch_zero_handler

`default_nettype wire

// [verification/zch_host_model.sv]
// Host-side line receiver model that accepts replies
`timescale 1ns/1ps
`default_nettype none
module zch_host_model (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic slow,
	output var  logic resp_ready
);
	logic [1:0] cnt_r;
	// one reply accepted at a time
	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_r      <= 2'h0;
			resp_ready <= 1'b0;
		end else begin
			cnt_r      <= cnt_r + 2'h1;
			resp_ready <= slow ? (cnt_r == 2'h3) : 1'b1;
		end
	end
endmodule : zch_host_model
`default_nettype wire

// [verification/test_zero_command_handler.sv]
// Self-checking bench for the zero command handler
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b, m) begin \
	comparisons++; \
	if ((a) !== (b)) begin \
		fail_count++; \
		$display("CHECK FAILED %0t %s", $time, m); \
	end \
end
module test_zero_command_handler;
	localparam int unsigned TMO = 20;
	localparam int unsigned WW  = zch_pkg::WEIGHT_W;
	logic                  clk = 1'b0, rst = 1'b1, slow = 1'b0;
	logic                  cmd_valid = 1'b0, cmd_imm = 1'b0;
	logic                  other_busy = 1'b0, weight_stable = 1'b0;
	logic                  pu_capture = 1'b0, tare_load = 1'b0;
	logic                  cts_pin = 1'b0, approved_pin = 1'b0;
	logic                  hs_enable_pin = 1'b0;
	logic                  cmd_ready, resp_valid, resp_ready;
	logic signed [WW-1:0]  raw_weight = '0, tare_value = '0;
	logic signed [WW-1:0]  zero_hi = 24'sd200, zero_lo = -24'sd200;
	logic signed [WW-1:0]  zero_ref, tare, gross, net, r;
	zch_pkg::zch_resp_type resp_code, exp_c;
	zch_pkg::zch_resp_type q[$];
	int                    fail_count = 0, comparisons = 0;

	always #50 clk = ~clk;

	zch_zero_handler #(.TIMEOUT_CYC(TMO)) i_zch_zero_handler (
		.clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_imm(cmd_imm),
		.cmd_ready(cmd_ready), .resp_valid(resp_valid),
		.resp_code(resp_code), .resp_ready(resp_ready),
		.other_busy(other_busy), .weight_stable(weight_stable),
		.raw_weight(raw_weight), .pu_capture(pu_capture),
		.zero_hi(zero_hi), .zero_lo(zero_lo), .tare_load(tare_load),
		.tare_value(tare_value), .cts_pin(cts_pin),
		.approved_pin(approved_pin), .hs_enable_pin(hs_enable_pin),
		.zero_ref(zero_ref), .tare(tare), .gross(gross), .net(net));

	zch_host_model i_zch_host_model (
		.clk(clk), .rst(rst), .slow(slow), .resp_ready(resp_ready));

	task automatic end_of_test();
		$display("Comparisons %0d, failures %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_of_test

	task automatic timed_out();
		fail_count++;
		$display("CHECK FAILED %0t wait limit reached", $time);
		end_of_test();
	endtask : timed_out

	task automatic drain();
		int n;
		n = 0;
		while (q.size() != 0 && n < 300) begin
			@(negedge clk);
			n++;
		end
		if (n >= 300)
			timed_out();
		repeat (3) @(posedge clk);
	endtask : drain

	// Send one command and wait until its reply has gone out
	task automatic send(input logic imm, input zch_pkg::zch_resp_type c);
		int n;
		n = 0;
		q.push_back(c);
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd_imm   <= imm;
		do begin
			@(negedge clk);
			n++;
		end while (!cmd_ready && n < 300);
		if (n >= 300)
			timed_out();
		@(posedge clk);
		cmd_valid <= 1'b0;
		@(negedge clk);
		`CHK(cmd_ready, 1'b0, "command taken")
		drain();
	endtask : send

	task automatic chkz(input logic signed [WW-1:0] z);
		@(negedge clk);
		`CHK(zero_ref, z, "zero reference")
		`CHK(tare, 24'sh0, "tare memory")
		`CHK(gross, raw_weight - z, "gross value")
		`CHK(net, raw_weight - z, "net value")
		@(posedge clk);
	endtask : chkz

	always @(negedge clk) begin
		if (!rst && resp_valid && resp_ready) begin
			if (q.size() == 0) begin
				fail_count++;
				$display("CHECK FAILED %0t unexpected reply", $time);
			end else begin
				exp_c = q.pop_front();
				`CHK(resp_code, exp_c, "reply code")
			end
		end
	end

	initial begin
		void'($urandom(49960));
		q.push_back(zch_pkg::RESP_SERIAL_ID);
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		drain();
		pu_capture <= 1'b1;
		tare_value <= 24'sh7;
		tare_load  <= 1'b1;
		@(posedge clk);
		pu_capture <= 1'b0;
		tare_load  <= 1'b0;
		r = $signed(WW'($urandom_range(200, 0))) - 24'sd100;
		raw_weight    <= r;
		weight_stable <= 1'b1;
		send(1'b1, zch_pkg::RESP_IMM_STABLE);
		chkz(r);
		weight_stable <= 1'b0;
		raw_weight    <= 24'sd150;
		send(1'b1, zch_pkg::RESP_IMM_DYN);
		chkz(24'sd150);
		other_busy <= 1'b1;
		send(1'b1, zch_pkg::RESP_IMM_BUSY);
		send(1'b0, zch_pkg::RESP_ZERO_BUSY);
		other_busy <= 1'b0;
		slow       <= 1'b1;
		raw_weight <= 24'sd250;
		send(1'b1, zch_pkg::RESP_IMM_PLUS);
		weight_stable <= 1'b1;
		send(1'b0, zch_pkg::RESP_ZERO_PLUS);
		raw_weight <= -24'sd250;
		send(1'b0, zch_pkg::RESP_ZERO_MINUS);
		send(1'b1, zch_pkg::RESP_IMM_MINUS);
		slow <= 1'b0;
		chkz(24'sd150);
		raw_weight    <= 24'sd40;
		weight_stable <= 1'b0;
		fork
			send(1'b0, zch_pkg::RESP_ZERO_ACK);
			begin
				repeat (8) @(posedge clk);
				weight_stable <= 1'b1;
			end
		join
		chkz(24'sd40);
		weight_stable <= 1'b0;
		raw_weight    <= 24'sd60;
		send(1'b0, zch_pkg::RESP_ZERO_BUSY);
		chkz(24'sd40);
		approved_pin  <= 1'b1;
		weight_stable <= 1'b1;
		repeat (4) @(posedge clk);
		send(1'b1, zch_pkg::RESP_UNSUPPORTED);
		chkz(24'sd40);
		send(1'b0, zch_pkg::RESP_ZERO_ACK);
		chkz(24'sd60);
		approved_pin  <= 1'b0;
		hs_enable_pin <= 1'b1;
		repeat (4) @(posedge clk);
		fork
			send(1'b1, zch_pkg::RESP_IMM_STABLE);
			begin
				repeat (20) @(negedge clk);
				`CHK(resp_valid, 1'b0, "reply held by handshake")
				@(posedge clk);
				cts_pin <= 1'b1;
			end
		join
		hs_enable_pin <= 1'b0;
		cts_pin       <= 1'b0;
		raw_weight    <= -24'sd30;
		repeat (4) @(posedge clk);
		send(1'b1, zch_pkg::RESP_IMM_STABLE);
		chkz(-24'sd30);
		end_of_test();
	end
endmodule : test_zero_command_handler
`default_nettype wire
